// File: core/seeaddr_slave.sv
// Summary of operation
// - Internal write cycle begins at stop ending a write and lasts until programming ends.
// - During the write cycle the data line stays released and address gets no acknowledge.
// - Transfers open with start, close with stop; receiver acknowledges accepted bytes.
// - Words are eight bits; a page is sixteen consecutive bytes.
// - Storage is split into 2048-bit page blocks of sixteen sixteen-byte pages.
// - Active address pins shrink with density: three, two, one, none.
// - Each active address bit must match its strap pin to select the part.
// - Unused strap positions carry the page-block selection; 16 Kbit decodes eight blocks.
// - All data moves on the master's serial clock; device never makes it.
// - Data pin is open drain: pulled low or released only.
// - Start is data falling while clock high; data changes only with clock low.
// - Transmitter releases after eight bits; receiver pulls low in the ninth clock.
`timescale 1ns/1ns
`default_nettype none

module seeaddr_slave
	import seeaddr_pkg::*;
#(
	parameter int BLOCK_SEL_BITS = 0,
	parameter int WRITE_CYCLES   = SEEADDR_WRITE_CYCLES
) (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_o,
	input  wire logic       strap_bit_low_i,
	input  wire logic       strap_bit_mid_i,
	input  wire logic       strap_bit_high_i,
	output var  logic       busy_o,
	output var  logic       wr_valid_o,
	output var  seeaddr_wr_t wr_o
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------

	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [2:0] strap_sync0;
	logic [2:0] strap_sync;
	logic       scl_d;
	logic       sda_d;

	// Two-stage synchronisers, then a delayed copy for edge finding.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_sync    <= 2'h3;
			sda_sync    <= 2'h3;
			strap_sync0 <= 3'h0;
			strap_sync  <= 3'h0;
			scl_d       <= 1'b1;
			sda_d       <= 1'b1;
		end else begin
			scl_sync    <= {scl_sync[0], scl_i};
			sda_sync    <= {sda_sync[0], sda_i};
			strap_sync0 <= {strap_bit_high_i, strap_bit_mid_i, strap_bit_low_i};
			strap_sync  <= strap_sync0;
			scl_d       <= scl_sync[1];
			sda_d       <= sda_sync[1];
		end
	end

	wire logic scl_s    = scl_sync[1];
	wire logic sda_s    = sda_sync[1];
	wire logic scl_rise = scl_s && !scl_d;
	wire logic scl_fall = !scl_s && scl_d;
	wire logic start_c  = scl_s && scl_d && sda_d && !sda_s;
	wire logic stop_c   = scl_s && scl_d && !sda_d && sda_s;

	// ----------------------------------------------------------------
	// Address match
	// ----------------------------------------------------------------

	logic [7:0] shift;
	logic [3:0] bit_cnt;

	// active pins are the upper ones, fewer with density.
	wire logic [2:0] pin_mask = 3'h7 << BLOCK_SEL_BITS;

	// type identifier then active strap bits must match.
	wire logic addr_hit = (shift[SEEADDR_TYPE_LO +: 4] == SEEADDR_TYPE_ID) &&
		(((shift[SEEADDR_SEL_HI:SEEADDR_SEL_LO] ^ strap_sync) & pin_mask) == 3'h0);

	// ----------------------------------------------------------------
	// Bus engine
	// ----------------------------------------------------------------

	seeaddr_state_t state;
	seeaddr_state_t ret_state;
	logic           pend_write;
	logic [2:0]     block;
	logic [7:0]     byte_addr;
	logic [31:0]    wait_cnt;

	// Byte shifter, acknowledge, stop and write-cycle sequencing.
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state      <= SEEADDR_IDLE;
			ret_state  <= SEEADDR_IDLE;
			shift      <= 8'h00;
			bit_cnt    <= 4'h0;
			sda_o      <= 1'b0;
			sda_oe_o   <= 1'b0;
			pend_write <= 1'b0;
			block      <= 3'h0;
			byte_addr  <= 8'h00;
			wait_cnt   <= 32'h0;
			busy_o     <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_o       <= '0;
		end else begin
			wr_valid_o <= 1'b0;
			if (state == SEEADDR_BUSY) begin
				// released line, no response during the write cycle
				sda_oe_o <= 1'b0;
				// back to idle once programming ends
				if (wait_cnt >= 32'(WRITE_CYCLES - 1)) begin
					state  <= SEEADDR_IDLE;
					busy_o <= 1'b0;
				end else begin
					wait_cnt <= wait_cnt + 32'h1;
				end
			end else if (stop_c) begin
				sda_oe_o <= 1'b0;
				bit_cnt  <= 4'h0;
				// stop ending a write starts the internal write cycle
				if (pend_write) begin
					state      <= SEEADDR_BUSY;
					busy_o     <= 1'b1;
					wait_cnt   <= 32'h0;
					pend_write <= 1'b0;
				end else begin
					state <= SEEADDR_IDLE;
				end
			end else if (start_c) begin
				state    <= SEEADDR_DEVAD;
				bit_cnt  <= 4'h0;
				sda_oe_o <= 1'b0;
			end else if (state != SEEADDR_IDLE) begin
				if (scl_rise && state != SEEADDR_ACK) begin
					shift   <= {shift[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end
				if (scl_fall && state == SEEADDR_ACK) begin
					// ninth clock over, release the line
					sda_oe_o <= 1'b0;
					state    <= ret_state;
					bit_cnt  <= 4'h0;
				end else if (scl_fall && bit_cnt == 4'h8) begin
					case (state)
						SEEADDR_DEVAD: begin
							// only write addressing is served here
							if (addr_hit && !shift[SEEADDR_RW_POS]) begin
								// unused strap positions pick the block
								block     <= shift[SEEADDR_SEL_HI:SEEADDR_SEL_LO] & ~pin_mask;
								ret_state <= SEEADDR_WORD;
								state     <= SEEADDR_ACK;
								sda_oe_o  <= 1'b1;
							end else begin
								state <= SEEADDR_IDLE;
							end
						end
						SEEADDR_WORD: begin
							// word address follows the slave address
							byte_addr <= shift;
							ret_state <= SEEADDR_DATA;
							state     <= SEEADDR_ACK;
							sda_oe_o  <= 1'b1;
						end
						SEEADDR_DATA: begin
							// page roll-over stays in the 16-byte page
							wr_o       <= '{block: block, byte_addr: byte_addr, data: shift};
							wr_valid_o <= 1'b1;
							pend_write <= 1'b1;
							byte_addr  <= {byte_addr[7:4], byte_addr[3:0] + 4'h1};
							ret_state  <= SEEADDR_DATA;
							state      <= SEEADDR_ACK;
							sda_oe_o   <= 1'b1;
						end
						default: begin
							state <= SEEADDR_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	a_busy_quiet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		busy_o |-> !sda_oe_o) else $error("Data line driven during write cycle.");
	a_stop_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(stop_c && pend_write && state != SEEADDR_BUSY) |=> busy_o)
		else $error("Write cycle did not start at stop.");
	a_drive_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sda_oe_o |-> !sda_o) else $error("Data line driven high.");
	a_ack_window: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(sda_oe_o) |-> $past(bit_cnt) == 4'h8) else $error("Acknowledge off the ninth bit.");
	a_busy_exit: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$fell(busy_o) |-> state == SEEADDR_IDLE) else $error("Bad state after write cycle.");
	a_start_seen: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(start_c && state != SEEADDR_BUSY && !stop_c) |=> state == SEEADDR_DEVAD)
		else $error("Start not taken.");

	// a slave address that misses leaves the line released and the engine idle.
	sequence s_addr_miss;
		state == SEEADDR_DEVAD && scl_fall && bit_cnt == 4'h8 && !addr_hit;
	endsequence
	a_addr_refuse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_addr_miss |=> (state == SEEADDR_IDLE && !sda_oe_o))
		else $error("Address miss was answered.");

endmodule

`default_nettype wire

// File: core/seeaddr_pkg.sv
package seeaddr_pkg;

	// Fixed four-bit type identifier (arbitrary value, not a real part code).
	localparam logic [3:0] SEEADDR_TYPE_ID = 4'h5;
	// Word width and page organisation.
	localparam int SEEADDR_WORD_BITS   = 8;
	localparam int SEEADDR_PAGE_BYTES  = 16;
	localparam int SEEADDR_BLOCK_PAGES = 16;
	localparam int SEEADDR_BLOCK_BITS  = SEEADDR_WORD_BITS * SEEADDR_PAGE_BYTES * SEEADDR_BLOCK_PAGES;
	// Slave-address field positions.
	localparam int SEEADDR_RW_POS    = 0;
	localparam int SEEADDR_SEL_LO    = 1;
	localparam int SEEADDR_SEL_HI    = 3;
	localparam int SEEADDR_TYPE_LO   = 4;
	// Internal write cycle time in microseconds and its cycle count at 100 MHz.
	localparam int SEEADDR_CLK_MHZ        = 100;
	localparam int SEEADDR_WRITE_CYCLE_US = 5000;
	localparam int SEEADDR_WRITE_CYCLES   = SEEADDR_WRITE_CYCLE_US * SEEADDR_CLK_MHZ;

	// Bus phase of the slave engine.
	typedef enum logic [2:0] {
		SEEADDR_IDLE  = 3'b000,
		SEEADDR_DEVAD = 3'b001,
		SEEADDR_WORD  = 3'b010,
		SEEADDR_DATA  = 3'b011,
		SEEADDR_ACK   = 3'b100,
		SEEADDR_BUSY  = 3'b101
	} seeaddr_state_t;

	// Decoded storage location handed to the array.
	typedef struct packed {
		logic [2:0] block;
		logic [7:0] byte_addr;
		logic [7:0] data;
	} seeaddr_wr_t;

endpackage

// File: tb/seeaddr_master.sv
`timescale 1ns/1ns
`default_nettype none
// -----------------------------
// Two-wire bus master model
// -----------------------------
module seeaddr_master (
	output var  logic scl_o,
	output var  logic sda_rel_o,
	input  wire logic sda_i
);
	// idle clock: both lines rest high between frames.
	initial begin
		scl_o = 1'b1;
		sda_rel_o = 1'b1;
	end
	// start: data falls while the clock is high.
	task automatic start();
		#40 sda_rel_o = 1'b0;
		#40 scl_o = 1'b0;
	endtask
	// stop: data rises while the clock is high.
	task automatic stop();
		#20 sda_rel_o = 1'b0;
		#20 scl_o = 1'b1;
		#40 sda_rel_o = 1'b1;
		#40;
	endtask
	// one clock; data only moves while the clock is low.
	task automatic bit_io(input logic b, output logic s);
		#20 sda_rel_o = b;
		#20 scl_o = 1'b1;
		#20 s = sda_i;
		#20 scl_o = 1'b0;
	endtask
	// eight bits first, then the line is released for the ninth.
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
endmodule
`default_nettype wire

// File: tb/serial_eeprom_i2c_addressing_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_i2c_addressing_tb;
	import seeaddr_pkg::*;
	typedef struct packed {
		logic [7:0] dev;
		logic [7:0] word;
		logic [7:0] data;
		logic       ack;
	} seeaddr_row_t;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        scl, sda_rel, sda_o, sda_oe, busy, wr_valid;
	logic        acked;
	logic [2:0]  strap = 3'b100;
	seeaddr_wr_t wr, got;
	int          bad_count = 0;
	int          tests_run = 0;
	int          nwr = 0;
	seeaddr_row_t rows [5] = '{'{8'h58, 8'h00, 8'h3C, 1'b1}, '{8'h5A, 8'hFF, 8'hC3, 1'b1},
		'{8'h38, 8'h01, 8'h11, 1'b0}, '{8'h5C, 8'h02, 8'h22, 1'b0}, '{8'h59, 8'h03, 8'h33, 1'b0}};
	// open drain: the line is low when any party pulls it.
	wire sda = sda_rel & ~(sda_oe & ~sda_o);
	// Clock generator.
	always #5 ref_clk = ~ref_clk;
	seeaddr_slave #(.BLOCK_SEL_BITS(1), .WRITE_CYCLES(200)) dut_u (.ref_clk_i(ref_clk),
		.reset_n_i(reset_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.strap_bit_low_i(strap[0]), .strap_bit_mid_i(strap[1]), .strap_bit_high_i(strap[2]),
		.busy_o(busy), .wr_valid_o(wr_valid), .wr_o(wr));
	seeaddr_master master_u (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));
	// Keeps the last accepted byte and counts them.
	always @(posedge ref_clk) begin
		if (wr_valid === 1'b1) begin
			got <= wr;
			nwr <= nwr + 1;
		end
	end
	// Compares and counts.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict.
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for the write cycle to end.
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 400) begin
			bad_count++;
			summarize();
		end
	endtask
	// One address, word and data frame closed by a stop.
	task automatic xfer(input logic [7:0] dev, w, d, input logic exp_ack);
		int n0;
		n0 = nwr;
		master_u.start();
		master_u.send(dev, acked);
		check(acked, exp_ack);
		if (acked === 1'b1) begin
			// the word address follows the slave address.
			master_u.send(w, acked);
			master_u.send(d, acked);
			check(acked, 1'b1);
		end
		master_u.stop();
		#100;
		check(32'(nwr - n0), exp_ack);
		if (exp_ack) begin
			check(got, {2'b00, dev[1], w, d});
			check(busy, 1'b1);
		end
	endtask
	// --------------------
	// Main sequence
	// --------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		check({busy, wr_valid, sda_oe}, 3'b000);
		#1 reset_n = 1'b1;
		#100;
		foreach (rows[i]) begin
			xfer(rows[i].dev, rows[i].word, rows[i].data, rows[i].ack);
			wait_idle();
			$display("row %0d done", i);
		end
		xfer(8'h58, 8'h40, 8'h77, 1'b1);
		xfer(8'h58, 8'h41, 8'h78, 1'b0);
		wait_idle();
		xfer(8'h58, 8'h42, 8'h79, 1'b1);
		wait_idle();
		$display("busy refusal done");
		master_u.start();
		master_u.send(8'h5A, acked);
		master_u.send(8'h1E, acked);
		for (int k = 0; k < 3; k++) begin
			master_u.send(8'h31 + 8'(k), acked);
		end
		#100;
		check(got, {3'b001, 8'h10, 8'h33});
		master_u.stop();
		check(busy, 1'b1);
		@(posedge ref_clk);
		#1 reset_n = 1'b0;
		#20;
		check(busy, 1'b0);
		@(posedge ref_clk);
		#1 reset_n = 1'b1;
		#100;
		xfer(8'h58, 8'h05, 8'hA5, 1'b1);
		wait_idle();
		$display("page wrap and reset done");
		summarize();
	end
endmodule
`default_nettype wire
